// [special_reg_write_guard_defs.vh]
`ifndef SPECIAL_REG_WRITE_GUARD_DEFS_VH
`define SPECIAL_REG_WRITE_GUARD_DEFS_VH

// register indices; byte address is four times the index
`define IDX_WAIT_CTRL     32'hFFFFF06E
`define IDX_UNLOCK_KEY    32'hFFFFF1FC
`define IDX_STATE_FLAGS   32'hFFFFF802
`define IDX_CLK_CTRL      32'hFFFFF828
`define IDX_WDT_RES_STAT  32'hFFFFF82A
`define IDX_WDT_MODE      32'hFFFFF6C2
`define IDX_PWR_SAVE      32'hFFFFF830
`define IDX_IRQ_STATUS    32'hFFFFF8F0
`define IDX_IRQ_MASK      32'hFFFFF8F4

// reset values
`define RST_WAIT_CTRL     8'h77
`define RST_STATE_FLAGS   8'h00
`define RST_CLK_CTRL      8'h03
`define RST_PWR_SAVE      8'h00
`define RST_WDT_RES_STAT  8'h00
`define RST_WDT_MODE      8'h00
`define RST_IRQ           3'h0

// field positions
`define WAIT_M_HI         2
`define WAIT_M_LO         0
`define FLAG_PROTECTION_ERROR_FLAG        0
`define IRQ_PROT_ERR      0
`define IRQ_PROT_OK       1
`define IRQ_BUS_HANG      2

// single-bit operation codes
`define BIT_OP_NONE       2'h0
`define BIT_OP_SET        2'h1
`define BIT_OP_CLR        2'h2
`define BIT_OP_NOT        2'h3

// timing: base access of three clocks is setup plus two access cycles
`define BASE_ACCESS_CLKS  4'h3
`define STALL_BASE        4'h2

`endif

// [access_wait_timer.v]
`include "special_reg_write_guard_defs.vh"

module access_wait_timer #(
  parameter CW = 10
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire          start,
  input  wire          advance,
  input  wire [CW-1:0] load_val,
  input  wire          hang_req,
  output wire          ready,
  output wire          hung
);

  reg [CW-1:0] cnt_q;
  reg          hang_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      cnt_q  <= {CW{1'b0}};
      hang_q <= 1'b0;
    end else begin
      if (start) begin
        cnt_q <= load_val;
      end else if (advance && cnt_q != {CW{1'b0}}) begin
        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
      // only reset releases a stall taken with the main clock gone
      if (start && hang_q == 1'b0 && hang_req) begin
        hang_q <= 1'b1;
      end
    end
  end

  assign ready = (cnt_q == {CW{1'b0}}) && !hang_q;
  assign hung  = hang_q;

endmodule

// [special_reg_write_guard.v]
// Summary of operation
// - unlock key is an 8-bit write-only register; reads return no content.
// - protected registers take a write only as first write after key.
// - protected write without a preceding key write sets the error flag.
// - other peripheral write right after key write sets the error flag.
// - plain reads between key and protected write keep the unlock, but a watchdog mode write after them sets the error flag.
// - writing 0 to the error flag clears it.
// - reset clears the whole state flags register to zero.
// - clearing the error flag right after a key write wins.
// - two consecutive key writes set the error flag.
// - state flags register accepts byte and single-bit accesses.
// - peripheral access takes three clocks with no wait configured.
// - wait control is 8-bit read/write, reset value 77h.
// - wait parameter m is bits 2 to 0 of wait control.
// - conflicting access stalls for extra (2 + m) times k clocks.
// - stall on subclock with main clock stopped holds until reset.
// - no interrupt acknowledge directly after a key write.
`include "special_reg_write_guard_defs.vh"

module special_reg_write_guard #(
  parameter AW = 16,
  parameter KW = 6,
  parameter CW = 10
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire [1:0]    bit_op_code,
  input  wire [2:0]    bit_op_pos,
  input  wire          ext_periph_wr,
  input  wire          ext_periph_rd,
  input  wire          periph_conflict,
  input  wire [KW-1:0] conflict_k,
  input  wire          cpu_on_subclock,
  input  wire          main_clock_stopped,
  output reg  [7:0]    cpu_clock_control_reg,
  output reg  [7:0]    power_save_control_reg,
  output reg  [7:0]    watchdog_reset_status_reg,
  output reg  [7:0]    watchdog_mode_reg,
  output wire [2:0]    wait_m,
  output wire          irq_hold_off,
  output wire          irq
);

  function addr_hit;
    input [AW-1:0] a;
    input [31:0]   idx;
    reg   [31:0]   byte_addr;
    begin
      byte_addr = {idx[29:0], 2'b00};
      addr_hit  = (a == byte_addr[AW-1:0]);
    end
  endfunction

  function [7:0] bit_apply;
    input [7:0] old;
    input [1:0] code;
    input [2:0] pos;
    input [7:0] wval;
    reg   [7:0] one;
    begin
      one = 8'h01 << pos;
      if (code == `BIT_OP_SET) begin
        bit_apply = old | one;
      end else if (code == `BIT_OP_CLR) begin
        bit_apply = old & ~one;
      end else if (code == `BIT_OP_NOT) begin
        bit_apply = old ^ one;
      end else begin
        bit_apply = wval;
      end
    end
  endfunction

  localparam [7:0] FLAGS_RST = `RST_STATE_FLAGS;

  reg  [7:0]    wait_ctrl_q;
  reg           protection_error_flag_q;
  reg           protection_error_flag_d;
  reg           unlocked_q;
  reg           unlocked_d;
  reg           rd_between_q;
  reg           rd_between_d;
  reg  [2:0]    irq_status_q;
  reg  [2:0]    irq_mask_q;
  reg  [2:0]    irq_event;
  reg           err_set;
  reg           prot_accept;
  reg  [7:0]    rd_mux;
  reg           sub_meta_q;
  reg           sub_sync_q;
  reg           stop_meta_q;
  reg           stop_sync_q;
  reg           hung_q;

  wire          setup_ph;
  wire          access_ph;
  wire          done;
  wire          bit_rmw;
  wire          eff_wr;
  wire          apb_rd;
  wire          h_wait;
  wire          h_key;
  wire          h_flags;
  wire          h_clk;
  wire          h_psc;
  wire          h_watchdog_reset_status_reg;
  wire          h_watchdog_mode_reg;
  wire          h_ist;
  wire          h_imsk;
  wire          h_prot;
  wire          mapped;
  wire [7:0]    wr_val;
  wire [CW-1:0] load_val;
  wire [CW-1:0] stall_extra;
  wire [CW-1:0] m_ext;
  wire [CW-1:0] k_ext;
  wire [CW-1:0] base_ext;
  wire          hang_req;
  wire          timer_ready;
  wire          timer_hung;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign done      = access_ph && timer_ready;
  assign pready    = timer_ready;
  assign bit_rmw   = (bit_op_code != `BIT_OP_NONE);
  // a single-bit operation is a read-modify-write and counts as a write
  assign eff_wr    = done && (pwrite || bit_rmw);
  assign apb_rd    = done && !pwrite && !bit_rmw;

  assign h_wait  = addr_hit(paddr, `IDX_WAIT_CTRL);
  assign h_key   = addr_hit(paddr, `IDX_UNLOCK_KEY);
  assign h_flags = addr_hit(paddr, `IDX_STATE_FLAGS);
  assign h_clk   = addr_hit(paddr, `IDX_CLK_CTRL);
  assign h_psc   = addr_hit(paddr, `IDX_PWR_SAVE);
  assign h_watchdog_reset_status_reg = addr_hit(paddr, `IDX_WDT_RES_STAT);
  assign h_watchdog_mode_reg  = addr_hit(paddr, `IDX_WDT_MODE);
  assign h_ist   = addr_hit(paddr, `IDX_IRQ_STATUS);
  assign h_imsk  = addr_hit(paddr, `IDX_IRQ_MASK);
  assign h_prot  = h_clk || h_psc || h_watchdog_reset_status_reg || h_watchdog_mode_reg;
  assign mapped  = h_wait || h_key || h_flags || h_prot || h_ist || h_imsk;
  // unmapped writes still end an unlock as other writes
  assign pslverr = done && !mapped;

  assign wait_m = wait_ctrl_q[`WAIT_M_HI:`WAIT_M_LO];

  // operands widened to the counter; sized for m = 7 and full k
  assign m_ext    = {{(CW-3){1'b0}}, wait_m};
  assign k_ext    = {{(CW-KW){1'b0}}, conflict_k};
  assign base_ext = {{(CW-4){1'b0}}, `BASE_ACCESS_CLKS} -
                    {{(CW-4){1'b0}}, 4'h2};
  assign stall_extra = periph_conflict ?
                       (({{(CW-4){1'b0}}, `STALL_BASE} + m_ext) * k_ext) :
                       {CW{1'b0}};
  assign load_val = base_ext + m_ext + stall_extra;
  assign hang_req = periph_conflict && sub_sync_q && stop_sync_q;

  access_wait_timer #(
    .CW (CW)
  ) u_timer (
    .clock    (clock),
    .rst_n    (rst_n),
    .start    (setup_ph),
    .advance  (access_ph),
    .load_val (load_val),
    .hang_req (hang_req),
    .ready    (timer_ready),
    .hung     (timer_hung)
  );

  // clock-state pins come from outside this domain
  always @(posedge clock) begin
    if (!rst_n) begin
      sub_meta_q  <= 1'b0;
      sub_sync_q  <= 1'b0;
      stop_meta_q <= 1'b0;
      stop_sync_q <= 1'b0;
      hung_q      <= 1'b0;
    end else begin
      sub_meta_q  <= cpu_on_subclock;
      sub_sync_q  <= sub_meta_q;
      stop_meta_q <= main_clock_stopped;
      stop_sync_q <= stop_meta_q;
      hung_q      <= timer_hung;
    end
  end

  // read value of the addressed register, before any bit operation
  always @* begin
    rd_mux = 8'h00;
    if (h_wait) begin
      rd_mux = wait_ctrl_q;
    end else if (h_flags) begin
      rd_mux = {7'h00, protection_error_flag_q};
    end else if (h_clk) begin
      rd_mux = cpu_clock_control_reg;
    end else if (h_psc) begin
      rd_mux = power_save_control_reg;
    end else if (h_watchdog_reset_status_reg) begin
      rd_mux = watchdog_reset_status_reg;
    end else if (h_watchdog_mode_reg) begin
      rd_mux = watchdog_mode_reg;
    end else if (h_ist) begin
      rd_mux = {5'h00, irq_status_q};
    end else if (h_imsk) begin
      rd_mux = {5'h00, irq_mask_q};
    end else begin
      rd_mux = 8'h00;
    end
  end

  assign wr_val = bit_apply(rd_mux, bit_op_code, bit_op_pos, pwdata[7:0]);

  // unlock sequencing and error detection
  // reads keep the unlock armed, any write ends it
  always @* begin
    err_set      = 1'b0;
    prot_accept  = 1'b0;
    unlocked_d   = unlocked_q;
    rd_between_d = rd_between_q;
    if (eff_wr && h_key) begin
      if (unlocked_q) begin
        err_set    = 1'b1;
        unlocked_d = 1'b0;
      end else begin
        unlocked_d = 1'b1;
      end
      rd_between_d = 1'b0;
    end else if (eff_wr && h_prot) begin
      if (!unlocked_q) begin
        err_set = 1'b1;
      end else if (h_watchdog_mode_reg && rd_between_q) begin
        // the read exemption does not cover the watchdog mode register
        err_set = 1'b1;
      end else begin
        prot_accept = 1'b1;
      end
      unlocked_d   = 1'b0;
      rd_between_d = 1'b0;
    end else if (eff_wr || ext_periph_wr) begin
      err_set      = unlocked_q;
      unlocked_d   = 1'b0;
      rd_between_d = 1'b0;
    end else if (unlocked_q && (apb_rd || ext_periph_rd)) begin
      rd_between_d = 1'b1;
    end
  end

  always @* begin
    protection_error_flag_d = protection_error_flag_q | err_set;
    if (eff_wr && h_flags) begin
      if (wr_val[`FLAG_PROTECTION_ERROR_FLAG] == 1'b0 && unlocked_q) begin
        protection_error_flag_d = 1'b0;
      end else if (wr_val[`FLAG_PROTECTION_ERROR_FLAG] == 1'b0) begin
        protection_error_flag_d = err_set;
      end else begin
        protection_error_flag_d = 1'b1;
      end
    end
  end

  always @* begin
    irq_event                = 3'h0;
    irq_event[`IRQ_PROT_ERR] = err_set;
    irq_event[`IRQ_PROT_OK]  = prot_accept;
    irq_event[`IRQ_BUS_HANG] = timer_hung && !hung_q;
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      wait_ctrl_q  <= `RST_WAIT_CTRL;
      protection_error_flag_q      <= FLAGS_RST[`FLAG_PROTECTION_ERROR_FLAG];
      unlocked_q   <= 1'b0;
      rd_between_q <= 1'b0;
      prdata       <= 32'h0000_0000;
    end else begin
      unlocked_q   <= unlocked_d;
      rd_between_q <= rd_between_d;
      protection_error_flag_q      <= protection_error_flag_d;
      if (eff_wr && h_wait) begin
        wait_ctrl_q <= wr_val;
      end
      // loaded on every selected cycle so the access phase holds the word
      if (psel) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // protected registers move only on an accepted unlock sequence
  always @(posedge clock) begin
    if (!rst_n) begin
      cpu_clock_control_reg     <= `RST_CLK_CTRL;
      power_save_control_reg    <= `RST_PWR_SAVE;
      watchdog_reset_status_reg <= `RST_WDT_RES_STAT;
      watchdog_mode_reg         <= `RST_WDT_MODE;
    end else begin
      if (prot_accept && h_clk) begin
        cpu_clock_control_reg <= wr_val;
      end
      if (prot_accept && h_psc) begin
        power_save_control_reg <= wr_val;
      end
      if (prot_accept && h_watchdog_reset_status_reg) begin
        watchdog_reset_status_reg <= wr_val;
      end
      if (prot_accept && h_watchdog_mode_reg) begin
        watchdog_mode_reg <= wr_val;
      end
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      irq_status_q <= `RST_IRQ;
      irq_mask_q   <= `RST_IRQ;
    end else begin
      if (eff_wr && h_imsk) begin
        irq_mask_q <= wr_val[2:0];
      end
      // new events win over a write-one clear in the same cycle
      if (eff_wr && h_ist) begin
        irq_status_q <= (irq_status_q & ~wr_val[2:0]) | irq_event;
      end else begin
        irq_status_q <= irq_status_q | irq_event;
      end
    end
  end

  // keeps key write and protected write back to back
  assign irq_hold_off = unlocked_q;
  assign irq          = |(irq_status_q & irq_mask_q);

endmodule

// [reg_guard_props.sv]
`include "special_reg_write_guard_defs.vh"
module reg_guard_props #(
  parameter AW = 16,
  parameter KW = 6,
  parameter CW = 10
) (
  input wire          clock,
  input wire          rst_n,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0]   pwdata,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  input wire [1:0]    bit_op_code,
  input wire [2:0]    bit_op_pos,
  input wire          ext_periph_wr,
  input wire          ext_periph_rd,
  input wire          periph_conflict,
  input wire [KW-1:0] conflict_k,
  input wire          cpu_on_subclock,
  input wire          main_clock_stopped,
  input wire [7:0]    cpu_clock_control_reg,
  input wire [7:0]    power_save_control_reg,
  input wire [7:0]    watchdog_reset_status_reg,
  input wire [7:0]    watchdog_mode_reg,
  input wire [2:0]    wait_m,
  input wire          irq_hold_off,
  input wire          irq
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam [AW-1:0] A_KEY = AW'(`IDX_UNLOCK_KEY * 4);
  localparam [AW-1:0] A_CLK = AW'(`IDX_CLK_CTRL * 4);
  wire done = psel && penable && pready;
  // bit ops count as writes whatever pwrite says
  wire wdone = done && (pwrite || bit_op_code != 2'h0);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_reset_vals: assert property ($rose(rst_n) |-> wait_m == 3'h7
    && !irq && !irq_hold_off) else $error("bad state after reset");
  a_setup_wait: assert property (psel && !penable |=> !pready)
    else $error("ready right after setup");
  a_base_time: assert property (psel && !penable && wait_m == 3'h0
    && !periph_conflict |=> !pready ##1 pready) else $error("not 3 clocks");
  a_slow_time: assert property (psel && !penable && wait_m == 3'h7
    && !periph_conflict |=> !pready [*8] ##1 pready)
    else $error("not 10 clocks");
  a_key_holds: assert property (wdone && paddr == A_KEY
    && !irq_hold_off |=> irq_hold_off) else $error("no hold off");
  a_unlock_used: assert property ((wdone || ext_periph_wr)
    && irq_hold_off |=> !irq_hold_off) else $error("unlock kept");
  a_locked_write: assert property (wdone && paddr == A_CLK
    && !irq_hold_off |=> $stable(cpu_clock_control_reg))
    else $error("locked write took");
  a_open_write: assert property (wdone && pwrite && paddr == A_CLK
    && bit_op_code == 2'h0 && irq_hold_off
    |=> cpu_clock_control_reg == $past(pwdata[7:0]))
    else $error("unlocked write lost");
  a_key_reads: assert property (done && !pwrite && paddr == A_KEY
    && bit_op_code == 2'h0 |-> prdata == 32'h0) else $error("key read");
  a_err_resp: assert property (pslverr |-> done && paddr != A_KEY
    && paddr != A_CLK) else $error("error on a mapped address");
endmodule
bind special_reg_write_guard reg_guard_props #(.AW(AW), .KW(KW), .CW(CW))
  u_props (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .bit_op_code, .bit_op_pos, .ext_periph_wr,
  .ext_periph_rd, .periph_conflict, .conflict_k, .cpu_on_subclock,
  .main_clock_stopped, .cpu_clock_control_reg, .power_save_control_reg,
  .watchdog_reset_status_reg, .watchdog_mode_reg, .wait_m, .irq_hold_off,
  .irq);

// [cpu_bus_model.sv]
module cpu_bus_model (
  input  logic        clock,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  output logic [1:0]  bit_op_code,
  output logic [2:0]  bit_op_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {psel, penable, pwrite, bit_op_code, bit_op_pos} = '0;
    paddr = '0;
    pwdata = '0;
  end
  // waits for the answer with no timeout; a hung access ends once reset frees the stall
  task automatic xfer(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic [1:0] op,
    output logic [31:0] rd, output logic err, output int n);
    @(posedge clock);
    {psel, penable, pwrite, bit_op_code} <= {1'b1, 1'b0, w, op};
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    n = 1;
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable, bit_op_code} <= '0;
    // released lines must not keep their last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// [testbench.sv]
`include "special_reg_write_guard_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0, rst_n = 0, ext_periph_wr = 0, ext_periph_rd = 0;
  logic        periph_conflict = 0, cpu_on_subclock = 0;
  logic        main_clock_stopped = 0;
  logic [5:0]  conflict_k = '0;
  logic [31:0] rv;
  logic        ev;
  int          nc, error_cnt = 0, total_checks = 0;
  wire         psel, penable, pwrite, pready, pslverr, irq_hold_off, irq;
  wire  [15:0] paddr;
  wire  [31:0] pwdata, prdata;
  wire  [1:0]  bit_op_code;
  wire  [2:0]  bit_op_pos, wait_m;
  wire  [7:0]  cpu_clock_control_reg, power_save_control_reg;
  wire  [7:0]  watchdog_reset_status_reg, watchdog_mode_reg;
  function automatic logic [15:0] ba(input logic [31:0] i);
    return 16'(i << 2);
  endfunction
  localparam logic [31:0] PI [4] = '{`IDX_CLK_CTRL, `IDX_PWR_SAVE,
    `IDX_WDT_RES_STAT, `IDX_WDT_MODE};
  wire [15:0] A_W = ba(`IDX_WAIT_CTRL), A_K = ba(`IDX_UNLOCK_KEY);
  wire [15:0] A_F = ba(`IDX_STATE_FLAGS), A_S = ba(`IDX_IRQ_STATUS);
  wire [15:0] A_M = ba(`IDX_IRQ_MASK);
  always #25 clock = ~clock;
  cpu_bus_model cpu (.clock, .prdata, .pready, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata, .bit_op_code, .bit_op_pos);
  special_reg_write_guard DUT (.clock, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .bit_op_code, .bit_op_pos,
    .ext_periph_wr, .ext_periph_rd, .periph_conflict, .conflict_k,
    .cpu_on_subclock, .main_clock_stopped, .cpu_clock_control_reg,
    .power_save_control_reg, .watchdog_reset_status_reg,
    .watchdog_mode_reg, .wait_m, .irq_hold_off, .irq);
  task automatic chk(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // sample after the completion edge has settled
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic [1:0] op = `BIT_OP_NONE);
    cpu.xfer(w, a, d, op, rv, ev, nc);
    #5;
  endtask
  task automatic pulse(input bit w);
    @(posedge clock);
    if (w) ext_periph_wr <= 1'b1;
    else ext_periph_rd <= 1'b1;
    @(posedge clock);
    {ext_periph_wr, ext_periph_rd} <= 2'b00;
    #5;
  endtask
  task automatic flags(input logic e, input string m);
    acc(0, A_F, 0);
    chk(rv, {31'h0, e}, m);
  endtask
  task automatic t_reset;
    acc(0, A_W, 0);
    chk(rv, 32'h77, "wait ctrl reset");
    chk(nc, 10, "access with m 7");
    flags(0, "flags reset");
    acc(0, A_K, 0);
    chk(rv, 0, "key read");
    $display("test reset done");
  endtask
  task automatic t_wait;
    acc(1, A_W, 32'h02);
    chk(wait_m, 2, "m field");
    acc(0, A_W, 0);
    chk(rv, 2, "wait readback");
    chk(nc, 5, "access with m 2");
    acc(1, A_W, 0);
    acc(0, A_W, 0);
    chk(nc, 3, "access no wait");
    acc(0, 16'h0FFC, 0);
    chk(ev, 1, "unmapped error");
    $display("test wait done");
  endtask
  task automatic t_unlock;
    logic [7:0] r [4];
    for (int i = 0; i < 4; i++) begin
      acc(1, A_K, 32'h5A);
      chk(irq_hold_off, 1, "hold off");
      if (i == 0) begin
        acc(0, A_W, 0);
        pulse(0);
      end
      acc(1, ba(PI[i]), 32'h50 + i);
      r = '{cpu_clock_control_reg, power_save_control_reg,
        watchdog_reset_status_reg, watchdog_mode_reg};
      chk(r[i], 32'h50 + i, "protected write");
      chk(irq_hold_off, 0, "unlock kept");
    end
    flags(0, "no error on sequence");
    chk(irq, 0, "masked irq");
    $display("test unlock done");
  endtask
  task automatic t_err;
    acc(1, A_M, 1);
    acc(1, ba(PI[0]), 32'hAA);
    chk(cpu_clock_control_reg, 8'h50, "locked write");
    flags(1, "locked write flag");
    chk(irq, 1, "irq raised");
    acc(1, A_S, 1);
    chk(irq, 0, "irq cleared");
    acc(1, A_F, 0);
    flags(0, "flag clear");
    acc(1, A_K, 0);
    acc(1, A_W, 0);
    flags(1, "other write");
    acc(1, A_M, 0);
    chk(irq, 0, "irq masked");
    acc(1, A_F, 0);
    acc(1, A_K, 0);
    acc(1, A_K, 0);
    flags(1, "double key");
    acc(1, A_K, 0);
    acc(1, A_F, 0);
    flags(0, "clear after key");
    acc(1, A_K, 0);
    acc(0, A_W, 0);
    acc(1, ba(PI[3]), 32'h99);
    chk(watchdog_mode_reg, 8'h53, "read breaks watchdog write");
    flags(1, "watchdog after read");
    acc(1, A_F, 0);
    acc(1, A_K, 0);
    pulse(1);
    chk(irq_hold_off, 0, "ext write relocks");
    flags(1, "ext write flag");
    acc(0, A_F, 0, `BIT_OP_CLR);
    flags(0, "bit clear");
    acc(0, A_F, 0, `BIT_OP_SET);
    flags(1, "bit set");
    acc(1, A_S, 7);
    $display("test errors done");
  endtask
  task automatic t_stall;
    @(posedge clock);
    periph_conflict <= 1'b1;
    conflict_k <= 6'h03;
    acc(0, A_W, 0);
    chk(nc, 9, "conflict stall");
    acc(1, A_M, 32'h04);
    @(posedge clock);
    {cpu_on_subclock, main_clock_stopped} <= 2'b11;
    repeat (3) @(posedge clock);
    fork
      acc(0, A_W, 0);
    join_none
    repeat (20) @(posedge clock);
    #5;
    chk(pready, 0, "stall held");
    chk(irq, 1, "hang irq");
    @(posedge clock);
    rst_n <= 1'b0;
    {periph_conflict, cpu_on_subclock, main_clock_stopped} <= '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    wait fork;
    @(posedge clock);
    #5;
    chk(pready, 1, "reset frees stall");
    chk(wait_m, 7, "wait ctrl reset again");
    acc(0, A_W, 0);
    chk(nc, 10, "access after reset");
    $display("test stall done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_wait;
    t_unlock;
    t_err;
    t_stall;
    test_done;
  end
endmodule
